/* adcs_pkg.sv */
// Shared constants and types for the converter sequencing block.
package adcs_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DS_RESULT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_SAR_RESULT = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h14;

  // Control register fields.
  localparam int CTRL_DS_START = 0;
  localparam int CTRL_DS_MODE_LO = 1;
  localparam int CTRL_DS_EN = 3;
  localparam int CTRL_SAR_EN = 4;
  localparam int CTRL_SAR_START = 5;
  localparam int CTRL_SAR_SINGLE = 6;
  localparam int CTRL_SAR_DIV_LO = 8;
  localparam int SAR_DIV_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0040;

  // Status register fields.
  localparam int ST_DS_DONE = 0;
  localparam int ST_SAR_DONE = 1;
  localparam int ST_DS_BUSY = 2;
  localparam int ST_SAR_BUSY = 3;
  localparam int ST_SAR_READY = 4;

  // Interrupt status and mask fields.
  localparam int IRQ_DS = 0;
  localparam int IRQ_SAR = 1;
  localparam int IRQ_W = 2;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int SAR_POWERUP_NS = 10_000;
  localparam int SAR_POWERUP_CYCLES = (SAR_POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SAR_CLK_MAX_HZ = 18_000_000;
  localparam int SAR_CLK_MIN_HZ = 1_000_000;
  localparam logic [SAR_DIV_W-1:0] SAR_DIV_MIN = 8'((CLK_HZ + SAR_CLK_MAX_HZ - 1) / SAR_CLK_MAX_HZ);
  localparam logic [SAR_DIV_W-1:0] SAR_DIV_MAX = 8'(CLK_HZ / SAR_CLK_MIN_HZ);
  localparam int SAR_TICKS_PER_SAMPLE = 18;
  localparam int SAR_BITS = 12;
  localparam int SAR_TRACK_TICKS = SAR_TICKS_PER_SAMPLE - SAR_BITS - 1;
  localparam int DS_PRIME_CONV = 3;
  localparam int DS_CONV_CYCLES = 64;
  localparam int DS_DATA_W = 16;

  typedef enum logic [1:0]
  {
    DS_SINGLE = 2'b00,
    DS_MULTI = 2'b01,
    DS_CONTINUOUS = 2'b10,
    DS_MULTI_TURBO = 2'b11
  } adcs_ds_mode_type;

  typedef enum logic [1:0]
  {
    DS_STANDBY = 2'b00,
    DS_CONVERT = 2'b01
  } adcs_ds_state_type;

  typedef enum logic [1:0]
  {
    SAR_IDLE = 2'b00,
    SAR_TRACK = 2'b01,
    SAR_STEP = 2'b10,
    SAR_FINISH = 2'b11
  } adcs_sar_state_type;

endpackage : adcs_pkg

/* adcs_sar_engine.sv */
// Successive-approximation search engine paced by the converter clock tick.
`timescale 1ns/100ps
module adcs_sar_engine
#(
  parameter int BITS = adcs_pkg::SAR_BITS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic start,
  input wire logic cmp_high,
  output logic [BITS-1:0] dac_code,
  output logic [BITS-1:0] result,
  output logic done,
  output logic busy
);
  import adcs_pkg::*;

  adcs_sar_state_type state;
  logic [4:0] track_cnt;
  logic [$clog2(BITS)-1:0] bit_idx;
  logic [BITS-1:0] next_code;

  // Keep the trial bit when the input is at or above the DAC level, then try the next lower bit.
  always_comb
  begin
    next_code = dac_code;
    if (!cmp_high)
      next_code[bit_idx] = 1'b0;
    if (bit_idx != '0)
      next_code[bit_idx - 1'b1] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= SAR_IDLE;
      track_cnt <= '0;
      bit_idx <= '0;
      dac_code <= '0;
      result <= '0;
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state)
        SAR_IDLE:
        begin
          if (start)
          begin
            state <= SAR_TRACK;
            track_cnt <= '0;
            busy <= 1'b1;
          end
        end
        SAR_TRACK:
        begin
          if (tick)
          begin
            track_cnt <= track_cnt + 5'h01;
            if (track_cnt == 5'(SAR_TRACK_TICKS - 1))
            begin
              state <= SAR_STEP;
              bit_idx <= ($clog2(BITS))'(BITS - 1);
              dac_code <= {1'b1, {(BITS-1){1'b0}}};
            end
          end
        end
        SAR_STEP:
        begin
          if (tick)
          begin
            dac_code <= next_code;
            if (bit_idx == '0)
              state <= SAR_FINISH;
            else
              bit_idx <= bit_idx - 1'b1;
          end
        end
        SAR_FINISH:
        begin
          if (tick)
          begin
            result <= dac_code;
            done <= 1'b1;
            busy <= 1'b0;
            state <= SAR_IDLE;
          end
        end
      endcase
    end
  end

endmodule : adcs_sar_engine

/* adcs_top.sv */
// Conversion sequencing for a delta-sigma and a successive-approximation converter, AXI4-Lite registers.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module adcs_top
#(
  parameter int DS_CONV_LEN = adcs_pkg::DS_CONV_CYCLES,
  parameter int DS_W = adcs_pkg::DS_DATA_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ds_start_pin,
  input wire logic [DS_W-1:0] ds_decim_data,
  output logic ds_decim_clear,
  output logic ds_eoc,
  input wire logic sar_start_pin,
  input wire logic sar_cmp,
  output logic [adcs_pkg::SAR_BITS-1:0] sar_dac_code,
  output logic sar_eoc,
  output logic irq
);
  import adcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [DS_W-1:0] ds_result;
  logic [SAR_BITS-1:0] sar_result;
  logic [31:0] wmask;
  logic wr_go;
  logic rd_go;
  logic [ADDR_W-1:0] rd_addr;
  logic ds_start_req;
  logic sar_start_req;

  adcs_ds_mode_type ds_mode;
  assign ds_mode = adcs_ds_mode_type'(ctrl[CTRL_DS_MODE_LO +: 2]);

  // Byte-lane mask built from the write strobes.
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign wmask[lane*8 +: 8] = {8{s_axi_wstrb[lane]}};
    end
  endgenerate

  // Write address and data are taken together in one cycle; bvalid rises on the same edge as awready and wready.
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        unique case (s_axi_awaddr)
          OFS_CTRL, OFS_STATUS, OFS_DS_RESULT, OFS_SAR_RESULT, OFS_IRQ_STATUS, OFS_IRQ_MASK:
            s_axi_bresp <= RESP_OKAY;
          default:
            s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Start bits are self-clearing; the clamped divider keeps the converter clock legal.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= CTRL_RESET;
    else if (wr_go && s_axi_awaddr == OFS_CTRL)
      ctrl <= (ctrl & ~wmask) | (s_axi_wdata & wmask);
    else
    begin
      ctrl[CTRL_DS_START] <= 1'b0;
      ctrl[CTRL_SAR_START] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= '0;
    else if (wr_go && s_axi_awaddr == OFS_IRQ_MASK && s_axi_wstrb[0])
      irq_mask <= s_axi_wdata[IRQ_W-1:0];
  end

  assign rd_addr = s_axi_araddr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flip-flops; edges are found after the second.
  logic [2:0] ds_pin_sync;
  logic [2:0] sar_pin_sync;
  logic [1:0] cmp_sync;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ds_pin_sync <= '0;
      sar_pin_sync <= '0;
      cmp_sync <= '0;
    end
    else
    begin
      ds_pin_sync <= {ds_pin_sync[1:0], ds_start_pin};
      sar_pin_sync <= {sar_pin_sync[1:0], sar_start_pin};
      cmp_sync <= {cmp_sync[0], sar_cmp};
    end
  end

  assign ds_start_req = ctrl[CTRL_DS_START] || (ds_pin_sync[1] && !ds_pin_sync[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Delta-sigma sequencer: each conversion lasts DS_CONV_LEN cycles.
  adcs_ds_state_type ds_state;
  logic [$clog2(DS_CONV_LEN)-1:0] ds_cycle;
  logic [1:0] ds_primed;
  logic ds_conv_end;
  logic ds_result_evt;
  logic ds_done;
  logic ds_read;

  assign ds_conv_end = ds_state == DS_CONVERT && ds_cycle == ($clog2(DS_CONV_LEN))'(DS_CONV_LEN - 1);
  assign ds_result_evt = ds_conv_end && ds_primed == 2'(DS_PRIME_CONV);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ds_state <= DS_STANDBY;
      ds_cycle <= '0;
      ds_primed <= '0;
      ds_decim_clear <= 1'b0;
    end
    else
    begin
      ds_decim_clear <= 1'b0;
      unique case (ds_state)
        DS_STANDBY:
        begin
          if (ctrl[CTRL_DS_EN] && ds_start_req)
          begin
            ds_state <= DS_CONVERT;
            ds_cycle <= '0;
            ds_primed <= '0;
            ds_decim_clear <= 1'b1;
          end
        end
        DS_CONVERT:
        begin
          // Starts seen here are dropped, so a running sample is never restarted.
          if (!ctrl[CTRL_DS_EN])
            ds_state <= DS_STANDBY;
          else if (ds_conv_end)
          begin
            ds_cycle <= '0;
            if (!ds_result_evt)
              ds_primed <= ds_primed + 2'b01;
            else if (ds_mode == DS_SINGLE)
              ds_state <= DS_STANDBY;
            else if (ds_mode != DS_CONTINUOUS)
            begin
              ds_primed <= '0;
              ds_decim_clear <= 1'b1;
            end
          end
          else
            ds_cycle <= ds_cycle + 1'b1;
        end
        default:
          ds_state <= DS_STANDBY;
      endcase
    end
  end

  // A new result at the same edge as a read keeps the flag set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ds_result <= '0;
      ds_done <= 1'b0;
    end
    else if (ds_result_evt)
    begin
      ds_result <= ds_decim_data;
      ds_done <= 1'b1;
    end
    else if (ds_read)
      ds_done <= 1'b0;
  end

  assign ds_eoc = ds_done;

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock tick; eighteen ticks make one sample.
  logic [SAR_DIV_W-1:0] sar_div;
  logic [SAR_DIV_W-1:0] sar_div_cnt;
  logic sar_tick;
  logic sar_en_q;
  logic [$clog2(SAR_POWERUP_CYCLES+1)-1:0] sar_wait;
  logic sar_ready;
  logic sar_busy;
  logic sar_fin;
  logic sar_done;
  logic sar_read;
  logic sar_go;

  always_comb
  begin
    sar_div = ctrl[CTRL_SAR_DIV_LO +: SAR_DIV_W];
    if (sar_div < SAR_DIV_MIN)
      sar_div = SAR_DIV_MIN;
    else if (sar_div > SAR_DIV_MAX)
      sar_div = SAR_DIV_MAX;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sar_div_cnt <= '0;
      sar_tick <= 1'b0;
    end
    else
    begin
      sar_tick <= sar_div_cnt >= sar_div - 1'b1;
      if (sar_div_cnt >= sar_div - 1'b1)
        sar_div_cnt <= '0;
      else
        sar_div_cnt <= sar_div_cnt + 1'b1;
    end
  end

  // Enable low means powered down; each rise restarts the settle wait.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sar_en_q <= 1'b0;
      sar_wait <= '0;
      sar_ready <= 1'b0;
    end
    else
    begin
      sar_en_q <= ctrl[CTRL_SAR_EN];
      if (!ctrl[CTRL_SAR_EN] || !sar_en_q)
      begin
        sar_wait <= '0;
        sar_ready <= 1'b0;
      end
      else if (sar_wait == ($clog2(SAR_POWERUP_CYCLES+1))'(SAR_POWERUP_CYCLES - 1))
        sar_ready <= 1'b1;
      else
        sar_wait <= sar_wait + 1'b1;
    end
  end

  assign sar_start_req = ctrl[CTRL_SAR_START] || (sar_pin_sync[1] && !sar_pin_sync[2]);
  // Continuous mode relaunches itself; starts while busy are not passed on.
  assign sar_go = sar_ready && !sar_busy && !sar_fin &&
    (sar_start_req || !ctrl[CTRL_SAR_SINGLE]);

  adcs_sar_engine #(.BITS(SAR_BITS)) u_engine
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(sar_tick),
    .start(sar_go),
    .cmp_high(cmp_sync[1]),
    .dac_code(sar_dac_code),
    .result(sar_result),
    .done(sar_fin),
    .busy(sar_busy)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sar_done <= 1'b0;
    else if (sar_fin)
      sar_done <= 1'b1;
    else if (sar_read)
      sar_done <= 1'b0;
  end

  assign sar_eoc = sar_done;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event bits; a new event beats a write-one-to-clear at the same edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= '0;
    else
    begin
      for (int i = 0; i < IRQ_W; i++)
      begin
        if ((i == IRQ_DS && ds_result_evt) || (i == IRQ_SAR && sar_fin))
          irq_status[i] <= 1'b1;
        else if (wr_go && s_axi_awaddr == OFS_IRQ_STATUS && s_axi_wstrb[0] && s_axi_wdata[i])
          irq_status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reading a result register is what releases its done flag.
  assign ds_read = rd_go && rd_addr == OFS_DS_RESULT;
  assign sar_read = rd_go && rd_addr == OFS_SAR_RESULT;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= '0;
        unique case (rd_addr)
          OFS_CTRL:
            s_axi_rdata <= ctrl;
          OFS_STATUS:
          begin
            s_axi_rdata[ST_DS_DONE] <= ds_done;
            s_axi_rdata[ST_SAR_DONE] <= sar_done;
            s_axi_rdata[ST_DS_BUSY] <= ds_state == DS_CONVERT;
            s_axi_rdata[ST_SAR_BUSY] <= sar_busy;
            s_axi_rdata[ST_SAR_READY] <= sar_ready;
          end
          OFS_DS_RESULT:
            s_axi_rdata[DS_W-1:0] <= ds_result;
          OFS_SAR_RESULT:
            s_axi_rdata[SAR_BITS-1:0] <= sar_result;
          OFS_IRQ_STATUS:
            s_axi_rdata[IRQ_W-1:0] <= irq_status;
          OFS_IRQ_MASK:
            s_axi_rdata[IRQ_W-1:0] <= irq_mask;
          default:
            s_axi_rresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : adcs_top

/* adcs_props.sv */
// Concurrent assertions on the ports of the converter sequencing block.
`timescale 1ns/100ps
module adcs_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ds_decim_clear,
  input wire logic ds_eoc,
  input wire logic sar_eoc,
  input wire logic irq
);
  import adcs_pkg::*;
  // Only a read of the matching result register may release a done flag, so writes are not excused.
  wire logic ds_cause = s_axi_arvalid && s_axi_araddr == OFS_DS_RESULT;
  wire logic sar_cause = s_axi_arvalid && s_axi_araddr == OFS_SAR_RESULT;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data accepted apart");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  b_rise_a: assert property ($rose(s_axi_bvalid) |-> s_axi_awready)
    else $error("bvalid rose without a write acceptance");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  r_rise_a: assert property ($rose(s_axi_rvalid) |-> s_axi_arready)
    else $error("rvalid rose without a read acceptance");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before rready");
  clr_pulse_a: assert property (ds_decim_clear |=> !ds_decim_clear)
    else $error("decimator clear longer than one cycle");
  ds_hold_a: assert property ($fell(ds_eoc) |-> $past(ds_cause))
    else $error("delta-sigma done dropped without a result read");
  sar_hold_a: assert property ($fell(sar_eoc) |-> $past(sar_cause))
    else $error("sar done dropped without a result read");
  irq_rise_a: assert property ($rose(irq) |-> $past(ds_eoc || sar_eoc) || $past(s_axi_awvalid, 2))
    else $error("interrupt rose without an event");
  irq_drop_a: assert property ($fell(irq) |-> $past(s_axi_awvalid, 2))
    else $error("interrupt dropped without a write");
endmodule : adcs_props

bind adcs_top adcs_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .ds_decim_clear, .ds_eoc, .sar_eoc, .irq);

/* adcs_partner.sv */
// Behavioural model of the analog side: comparator and decimator.
`timescale 1ns/100ps
module adcs_partner
#(
  parameter int CONV_LEN = 8
)
(
  input wire logic aclk,
  input wire logic ds_decim_clear,
  input wire logic [adcs_pkg::SAR_BITS-1:0] sar_dac_code,
  input wire logic [adcs_pkg::SAR_BITS-1:0] vin,
  input wire logic [adcs_pkg::DS_DATA_W-1:0] level,
  output logic sar_cmp,
  output logic [adcs_pkg::DS_DATA_W-1:0] ds_decim_data
);
  import adcs_pkg::*;
  int age = 1000;
  always @(posedge aclk)
  begin
    if (ds_decim_clear === 1'h1)
      age <= 0;
    else if (age < 1000)
      age <= age + 1;
  end
  assign sar_cmp = (vin >= sar_dac_code);
  // Until three conversions have primed it, the output is junk, so an early sample is caught.
  assign ds_decim_data = (age >= 3 * CONV_LEN) ? level : ~level;
endmodule : adcs_partner

/* adcs_top_tb.sv */
// Self-checking bench for the converter sequencing block.
`timescale 1ns/100ps
module adcs_top_tb;
  import adcs_pkg::*;
  localparam int LEN = 8;
  localparam int SDIV = 6;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic ds_start_pin = 1'h0, sar_start_pin = 1'h0, ds_decim_clear, ds_eoc, sar_cmp, sar_eoc, irq;
  logic [15:0] ds_decim_data, level = 16'h0;
  logic [11:0] sar_dac_code, vin = 12'h0;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n_clr = 0;
  always #5 aclk = ~aclk;
  adcs_top #(.DS_CONV_LEN(LEN)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ds_start_pin, .ds_decim_data, .ds_decim_clear, .ds_eoc, .sar_start_pin, .sar_cmp, .sar_dac_code,
    .sar_eoc, .irq);
  adcs_partner #(.CONV_LEN(LEN)) i_partner (.aclk, .ds_decim_clear, .sar_dac_code, .vin, .level, .sar_cmp,
    .ds_decim_data);
  ////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (ds_decim_clear === 1'h1)
      n_clr <= n_clr + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int n, input int lo, input int hi);
    num_checks++;
    if (n < lo || n > hi)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask : chk_in
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
      @(posedge aclk);
    while (s_axi_awready !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    while (s_axi_bvalid !== 1'h1)
      @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
      @(posedge aclk);
    while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1)
      @(posedge aclk);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wait_eoc(input bit s, output int n);
    n = 0;
    while ((s ? sar_eoc : ds_eoc) !== 1'h1)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_eoc
  ////////////////////////////////////////
  task automatic t_regs;
    rd(OFS_CTRL);
    chk(rdv, CTRL_RESET);
    rd(6'h18);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(6'h1C, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(OFS_STATUS, 32'h1F);
    rd(OFS_STATUS);
    chk(rdv, 32'h0);
  endtask : t_regs
  task automatic t_ds_single;
    int t0, n, c0;
    level <= 16'h1234;
    wr(OFS_IRQ_MASK, 32'h1);
    c0 = n_clr;
    wr(OFS_CTRL, 32'h49);
    t0 = cyc;
    repeat (10) @(posedge aclk);
    wr(OFS_CTRL, 32'h49);
    wait_eoc(0, n);
    chk_in(cyc - t0, 4 * LEN - 4, 4 * LEN + 8);
    chk(n_clr - c0, 32'h1);
    rd(OFS_STATUS);
    chk(32'(rdv[ST_DS_DONE]), 32'h1);
    chk(32'(irq), 32'h1);
    rd(OFS_DS_RESULT);
    chk(rdv, 32'h1234);
    @(posedge aclk);
    chk(32'(ds_eoc), 32'h0);
    wr(OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    repeat (60) @(posedge aclk);
    chk(32'(ds_eoc), 32'h0);
  endtask : t_ds_single
  task automatic t_ds_multi;
    int t0, n, c0;
    level <= 16'h0A0A;
    wr(OFS_CTRL, 32'h4A);
    c0 = n_clr;
    ds_start_pin <= 1'h1;
    t0 = cyc;
    repeat (4) @(posedge aclk);
    ds_start_pin <= 1'h0;
    wait_eoc(0, n);
    chk_in(cyc - t0, 4 * LEN - 4, 4 * LEN + 10);
    rd(OFS_DS_RESULT);
    chk(rdv, 32'h0A0A);
    level <= 16'h5151;
    @(posedge aclk);
    wait_eoc(0, n);
    chk_in(n, 2 * LEN, 4 * LEN + 4);
    chk_in(n_clr - c0, 2, 3);
    rd(OFS_DS_RESULT);
    chk(rdv, 32'h5151);
    // The turbo code must behave as multi-sample: the next sample re-primes on its own.
    wr(OFS_CTRL, 32'h4E);
    c0 = n_clr;
    wait_eoc(0, n);
    rd(OFS_DS_RESULT);
    chk(rdv, 32'h5151);
    chk_in(n_clr - c0, 1, 2);
    wr(OFS_CTRL, 32'h40);
    rd(OFS_DS_RESULT);
  endtask : t_ds_multi
  task automatic t_ds_cont;
    int t0, n;
    wr(OFS_CTRL, 32'h4D);
    t0 = cyc;
    wait_eoc(0, n);
    chk_in(cyc - t0, 4 * LEN - 4, 4 * LEN + 8);
    rd(OFS_DS_RESULT);
    @(posedge aclk);
    wait_eoc(0, n);
    chk_in(n, 0, LEN);
    wr(OFS_CTRL, 32'h40);
    rd(OFS_DS_RESULT);
  endtask : t_ds_cont
  task automatic t_sar;
    int t0, n;
    logic [11:0] codes [4] = '{12'hFFF, 12'h000, 12'h800, 12'h7FF};
    vin <= 12'hA5C;
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h3);
    wr(OFS_CTRL, 32'h0650);
    wr(OFS_CTRL, 32'h0670);
    rd(OFS_STATUS);
    chk(rdv & 32'h18, 32'h0);
    repeat (SAR_POWERUP_CYCLES + 10) @(posedge aclk);
    rd(OFS_STATUS);
    chk(rdv & 32'h1A, 32'h10);
    sar_start_pin <= 1'h1;
    t0 = cyc;
    repeat (4) @(posedge aclk);
    sar_start_pin <= 1'h0;
    repeat (20) @(posedge aclk);
    wr(OFS_CTRL, 32'h0670);
    wait_eoc(1, n);
    chk_in(cyc - t0, 17 * SDIV, 19 * SDIV + 8);
    rd(OFS_STATUS);
    chk(rdv & 32'h2, 32'h2);
    rd(OFS_SAR_RESULT);
    chk(rdv, 32'hA5C);
    @(posedge aclk);
    chk(32'(sar_eoc), 32'h0);
    foreach (codes[i])
    begin
      vin <= codes[i];
      wr(OFS_CTRL, 32'h0670);
      wait_eoc(1, n);
      rd(OFS_SAR_RESULT);
      chk(rdv, 32'(codes[i]));
    end
    repeat (150) @(posedge aclk);
    chk(32'(sar_eoc), 32'h0);
    rd(OFS_IRQ_STATUS);
    chk(rdv, 32'h2);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_MASK, 32'h0);
    vin <= 12'h3C3;
    wr(OFS_CTRL, 32'h0610);
    wait_eoc(1, n);
    rd(OFS_SAR_RESULT);
    chk(rdv, 32'h3C3);
    @(posedge aclk);
    wait_eoc(1, n);
    chk_in(n, 0, 18 * SDIV + 8);
    rd(OFS_SAR_RESULT);
    chk(rdv, 32'h3C3);
    wr(OFS_CTRL, 32'h0650);
    rd(OFS_SAR_RESULT);
  endtask : t_sar
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_ds_single();
    t_ds_multi();
    t_ds_cont();
    t_sar();
    finish_test();
  end
endmodule : adcs_top_tb
